// *** core/dit_timer.sv ***
// two interval timers with command condition codes, interrupts and resets
`default_nettype none
module dit_timer
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sys_reset,
    input wire logic halt_io,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic cmd_timer,
    input wire logic [15:0] cmd_data,
    input wire logic cmd_parity_err,
    output logic cc_valid,
    output logic [2:0] cc,
    output logic [15:0] rd_data,
    input wire logic [1:0] ext_clk,
    input wire logic [1:0] ext_gate,
    input wire logic [1:0] irq_ack,
    output logic [1:0] irq_req,
    output logic [2:0] irq_cc0,
    output logic [2:0] irq_cc1,
    output logic [1:0] run_state
);
    import dit_pkg::*;

    dit_state_t s;
    dit_state_t next_s;
    logic [1:0] dev_end;
    logic [1:0] gate_end;
    logic [1:0] pulse;

    function automatic logic int_pulse(input logic [2:0] code, input logic t1, input logic t5,
                                       input logic t25, input logic t100);
        logic r;
        r = 1'b0;
        unique case (code)
            TB_CODE_000: r = t100;
            TB_CODE_010: r = t25;
            TB_CODE_100: r = t5;
            TB_CODE_110: r = t1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : int_pulse

    always_comb
    begin
        logic us_tick;
        logic busy;
        logic tb_ext;
        us_tick = 1'b0;
        busy = 1'b0;
        tb_ext = 1'b0;
        next_s = s;
        dev_end = 2'b00;
        gate_end = 2'b00;
        pulse = 2'b00;
        next_s.cc_valid = 1'b0;
        // free-running timebase, not aligned to any start
        us_tick = (s.us_div == US_DIV_LAST);
        next_s.us_div = us_tick ? 7'h00 : s.us_div + 7'h01;
        if (us_tick)
        begin
            next_s.div5 = (s.div5 == TB_PERIOD_100_US - 7'h01) ? 7'h00 : s.div5 + 7'h01;
            next_s.div25 = (s.div25 == TB_PERIOD_010_US - 7'h01) ? 7'h00 : s.div25 + 7'h01;
            next_s.div100 = (s.div100 == TB_PERIOD_000_US - 7'h01) ? 7'h00 : s.div100 + 7'h01;
        end
        for (int i = 0; i < 2; i++)
        begin
            next_s.t[i].clk_s1 = ext_clk[i];
            next_s.t[i].clk_s2 = s.t[i].clk_s1;
            next_s.t[i].clk_prev = s.t[i].clk_s2;
            next_s.t[i].gate_s1 = ext_gate[i];
            next_s.t[i].gate_s2 = s.t[i].gate_s1;
            next_s.t[i].gate_prev = s.t[i].gate_s2;
            tb_ext = s.t[i].mode[MODE_EXT_CLK_BIT];
            pulse[i] = tb_ext ? (s.t[i].clk_s2 & ~s.t[i].clk_prev)
                : int_pulse(s.t[i].mode[MODE_TB_LSB+2:MODE_TB_LSB], us_tick,
                            us_tick && s.div5 == 7'h00, us_tick && s.div25 == 7'h00,
                            us_tick && s.div100 == 7'h00);
            if (s.t[i].run && s.t[i].mode[MODE_GATE_BIT] && !s.t[i].counting
                && s.t[i].gate_s2 && !s.t[i].gate_prev)
            begin
                next_s.t[i].counting = 1'b1;
            end
            if (s.t[i].run && s.t[i].counting && pulse[i])
            begin
                if (s.t[i].cnt == 16'h0000)
                begin
                    dev_end[i] = 1'b1;
                    next_s.t[i].cnt = s.t[i].periodic ? s.t[i].autold : CNT_POR_VALUE;
                end
                else
                begin
                    next_s.t[i].cnt = s.t[i].cnt - 16'h0001;
                end
            end
            gate_end[i] = s.t[i].run && s.t[i].mode[MODE_GATE_BIT] && s.t[i].counting
                && !s.t[i].gate_s2 && s.t[i].gate_prev;
            if (gate_end[i])
            begin
                next_s.t[i].run = 1'b0;
                next_s.t[i].counting = 1'b0;
            end
            if (irq_ack[i])
            begin
                next_s.t[i].pend = 1'b0;
                next_s.t[i].ovr = 1'b0;
            end
            if (s.t[i].prep[PREP_IE_BIT])
            begin
                if (gate_end[i])
                begin
                    next_s.t[i].pend = 1'b1;
                    next_s.t[i].icc = dev_end[i] ? ICC_ATTN_DE
                        : (s.t[i].ovr ? ICC_ATTN_EXC : ICC_ATTENTION);
                end
                else if (dev_end[i])
                begin
                    next_s.t[i].pend = 1'b1;
                    if (s.t[i].pend)
                    begin
                        next_s.t[i].ovr = 1'b1;
                        next_s.t[i].icc = ICC_EXCEPTION;
                    end
                    else
                    begin
                        next_s.t[i].icc = ICC_DEVICE_END;
                    end
                end
            end
        end
        if (cmd_valid)
        begin
            next_s.cc_valid = 1'b1;
            next_s.cc = CC_OK;
            busy = s.t[cmd_timer].run || s.t[cmd_timer].pend;
            unique case (cmd_op)
                OP_PREPARE, OP_READ_ID, OP_READ_VALUE, OP_READ_MODE:
                begin
                    if (cmd_parity_err)
                    begin
                        next_s.cc = CC_DATA_CHECK;
                    end
                    else if (cmd_op == OP_PREPARE)
                    begin
                        next_s.t[cmd_timer].prep = cmd_data;
                    end
                    else
                    begin
                        next_s.rd_data = (cmd_op == OP_READ_ID) ? DEVICE_ID
                            : (cmd_op == OP_READ_VALUE) ? s.t[cmd_timer].cnt : s.t[cmd_timer].mode;
                    end
                end
                OP_SET_PERIOD, OP_SET_MODE, OP_START_PER, OP_START_APER:
                begin
                    if (busy)
                    begin
                        next_s.cc = CC_BUSY;
                    end
                    else if (cmd_parity_err)
                    begin
                        next_s.cc = CC_DATA_CHECK;
                    end
                    else if (cmd_op == OP_SET_PERIOD)
                    begin
                        next_s.t[cmd_timer].cnt = cmd_data;
                        next_s.t[cmd_timer].autold = cmd_data;
                    end
                    else if (cmd_op == OP_SET_MODE)
                    begin
                        next_s.t[cmd_timer].mode = cmd_data;
                    end
                    else
                    begin
                        next_s.t[cmd_timer].run = 1'b1;
                        next_s.t[cmd_timer].counting = !s.t[cmd_timer].mode[MODE_GATE_BIT];
                        next_s.t[cmd_timer].periodic = (cmd_op == OP_START_PER);
                    end
                end
                OP_STOP:
                begin
                    if (s.t[cmd_timer].pend)
                    begin
                        next_s.cc = CC_BUSY;
                    end
                    else if (cmd_parity_err)
                    begin
                        next_s.cc = CC_DATA_CHECK;
                    end
                    else
                    begin
                        next_s.t[cmd_timer].run = 1'b0;
                        next_s.t[cmd_timer].counting = 1'b0;
                        next_s.t[cmd_timer].pend = 1'b0;
                        next_s.t[cmd_timer].ovr = 1'b0;
                    end
                end
                OP_DEV_RESET:
                begin
                    next_s.t[cmd_timer].mode = 16'h0000;
                    next_s.t[cmd_timer].pend = 1'b0;
                    next_s.t[cmd_timer].ovr = 1'b0;
                    next_s.t[cmd_timer].run = 1'b0;
                    next_s.t[cmd_timer].counting = 1'b0;
                end
                default:
                begin
                    next_s.cc = CC_REJECT;
                end
            endcase
        end
        for (int i = 0; i < 2; i++)
        begin
            if (sys_reset || halt_io)
            begin
                next_s.t[i].mode = 16'h0000;
                next_s.t[i].pend = 1'b0;
                next_s.t[i].ovr = 1'b0;
                next_s.t[i].run = 1'b0;
                next_s.t[i].counting = 1'b0;
            end
            if (sys_reset)
            begin
                next_s.t[i].prep = 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.t[0].cnt <= CNT_POR_VALUE;
            s.t[0].autold <= CNT_POR_VALUE;
            s.t[1].cnt <= CNT_POR_VALUE;
            s.t[1].autold <= CNT_POR_VALUE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign cc_valid = s.cc_valid;
    assign cc = s.cc;
    assign rd_data = s.rd_data;
    assign irq_cc0 = s.t[0].icc;
    assign irq_cc1 = s.t[1].icc;
    assign irq_req = {s.t[1].pend, s.t[0].pend};
    assign run_state = {s.t[1].run, s.t[0].run};

    default clocking dit_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_busy_refuse: assert property (cmd_valid && cmd_op == OP_START_PER && (s.t[cmd_timer].run
        || s.t[cmd_timer].pend) && !sys_reset && !halt_io |=> cc_valid && cc == CC_BUSY)
        else $error("busy timer accepted a start");
    a_reject_code: assert property (cmd_valid && cmd_op == 8'hFF |=> cc == CC_REJECT)
        else $error("unknown command not rejected");
    a_parity_check: assert property (cmd_valid && cmd_parity_err && cmd_op == OP_READ_ID
        |=> cc_valid && cc == CC_DATA_CHECK)
        else $error("parity error not reported");
    a_cc_legal: assert property (cc_valid |-> cc == CC_OK || cc == CC_BUSY
        || cc == CC_REJECT || cc == CC_DATA_CHECK)
        else $error("illegal command condition code");
    a_irq_enable: assert property ($rose(irq_req[0]) |-> $past(s.t[0].prep[PREP_IE_BIT]))
        else $error("interrupt without enable");
    a_devend_code: assert property (dev_end[0] && !gate_end[0] && !s.t[0].pend
        && s.t[0].prep[PREP_IE_BIT] && !sys_reset && !halt_io && !cmd_valid
        |=> irq_req[0] && irq_cc0 == ICC_DEVICE_END)
        else $error("device end not reported as 3");
    a_overrun_code: assert property (dev_end[0] && !gate_end[0] && s.t[0].pend
        && s.t[0].prep[PREP_IE_BIT] && !sys_reset && !halt_io && !cmd_valid
        |=> irq_req[0] && irq_cc0 == ICC_EXCEPTION)
        else $error("overrun not reported as 2");
    a_gate_attn: assert property (gate_end[0] && !dev_end[0] && !s.t[0].ovr
        && s.t[0].prep[PREP_IE_BIT] && !sys_reset && !halt_io && !cmd_valid
        |=> !run_state[0] && irq_cc0 == ICC_ATTENTION)
        else $error("gate end not reported as 4");
    a_reload_per: assert property (dev_end[0] && s.t[0].periodic && !cmd_valid
        |=> s.t[0].cnt == $past(s.t[0].autold))
        else $error("periodic reload missing");
    a_gate_wait: assert property (s.t[0].run && !s.t[0].counting && !cmd_valid
        |=> s.t[0].cnt == $past(s.t[0].cnt))
        else $error("counter moved before gate");
    a_por_ones: assert property ($past(nrst) == 1'b0 |-> s.t[1].cnt == CNT_POR_VALUE
        && !run_state[1] && !irq_req[1])
        else $error("power-on state wrong");
endmodule : dit_timer
`default_nettype wire

// *** inc/dit_pkg.sv ***
// constants and types shared by the dual interval timer
`default_nettype none
package dit_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam logic [6:0] US_DIV_LAST = 7'(CYC_PER_US - 1);
    localparam logic [6:0] TB_PERIOD_000_US = 7'h64;
    localparam logic [6:0] TB_PERIOD_010_US = 7'h19;
    localparam logic [6:0] TB_PERIOD_100_US = 7'h05;
    localparam logic [2:0] TB_CODE_000 = 3'h0;
    localparam logic [2:0] TB_CODE_010 = 3'h2;
    localparam logic [2:0] TB_CODE_100 = 3'h4;
    localparam logic [2:0] TB_CODE_110 = 3'h6;
    localparam int MODE_GATE_BIT = 0;
    localparam int MODE_EXT_CLK_BIT = 1;
    localparam int MODE_TB_LSB = 1;
    localparam int PREP_IE_BIT = 0;
    localparam logic [15:0] CNT_POR_VALUE = 16'hFFFF;
    localparam logic [15:0] DEVICE_ID = 16'h5A00; // arbitrary neutral value
    localparam logic [7:0] OP_PREPARE = 8'h60;
    localparam logic [7:0] OP_SET_PERIOD = 8'h62;
    localparam logic [7:0] OP_SET_MODE = 8'h63;
    localparam logic [7:0] OP_START_PER = 8'h66;
    localparam logic [7:0] OP_START_APER = 8'h67;
    localparam logic [7:0] OP_STOP = 8'h6E;
    localparam logic [7:0] OP_DEV_RESET = 8'h6F;
    localparam logic [7:0] OP_READ_ID = 8'h20;
    localparam logic [7:0] OP_READ_VALUE = 8'h24;
    localparam logic [7:0] OP_READ_MODE = 8'h25;
    localparam logic [2:0] CC_BUSY = 3'h1;
    localparam logic [2:0] CC_REJECT = 3'h3;
    localparam logic [2:0] CC_DATA_CHECK = 3'h5;
    localparam logic [2:0] CC_OK = 3'h7;
    localparam logic [2:0] ICC_EXCEPTION = 3'h2;
    localparam logic [2:0] ICC_DEVICE_END = 3'h3;
    localparam logic [2:0] ICC_ATTENTION = 3'h4;
    localparam logic [2:0] ICC_ATTN_EXC = 3'h6;
    localparam logic [2:0] ICC_ATTN_DE = 3'h7;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] autold;
        logic [15:0] prep;
        logic [15:0] mode;
        logic run;
        logic counting;
        logic periodic;
        logic pend;
        logic ovr;
        logic [2:0] icc;
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic gate_s1;
        logic gate_s2;
        logic gate_prev;
    } dit_tmr_t;

    typedef struct packed {
        dit_tmr_t [1:0] t;
        logic [6:0] us_div;
        logic [6:0] div5;
        logic [6:0] div25;
        logic [6:0] div100;
        logic cc_valid;
        logic [2:0] cc;
        logic [15:0] rd_data;
    } dit_state_t;
endpackage : dit_pkg
`default_nettype wire

// *** testbench/dit_cust_model.sv ***
// customer equipment model: clock pulses and gate lines for both timers
`default_nettype none
module dit_cust_model
(
    input wire logic ref_clk,
    input wire logic [1:0] run_state,
    input wire logic [1:0] pulse_req,
    input wire logic [1:0] gate_req,
    output logic [1:0] ext_clk,
    output logic [1:0] ext_gate
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock line rests low between requested pulses
    assign ext_clk = pulse_req;
    // gate may only rise once the timer shows run state
    always_ff @(posedge ref_clk)
    begin
        ext_gate <= gate_req & (ext_gate | run_state);
    end
endmodule : dit_cust_model
`default_nettype wire

// *** testbench/dual_interval_timer_status_tb_top.sv ***
// self-checking bench for the dual interval timer
`default_nettype none
module dual_interval_timer_status_tb_top;
    import dit_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, nrst, sys_reset, halt_io, cmd_valid, cmd_timer, cmd_parity_err, cc_valid;
    logic [7:0] cmd_op;
    logic [15:0] cmd_data, rd_data, v;
    logic [2:0] cc, irq_cc0, irq_cc1;
    logic [1:0] ext_clk, ext_gate, irq_ack, irq_req, run_state, pulse_req, gate_req;
    int mismatches = 0;
    int check_count = 0;
    int n;
    dit_timer dut_u (.ref_clk(ref_clk), .nrst(nrst), .sys_reset(sys_reset), .halt_io(halt_io),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_timer(cmd_timer), .cmd_data(cmd_data),
        .cmd_parity_err(cmd_parity_err), .cc_valid(cc_valid), .cc(cc), .rd_data(rd_data),
        .ext_clk(ext_clk), .ext_gate(ext_gate), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_cc0(irq_cc0), .irq_cc1(irq_cc1), .run_state(run_state));
    dit_cust_model cust_u (.ref_clk(ref_clk), .run_state(run_state), .pulse_req(pulse_req),
        .gate_req(gate_req), .ext_clk(ext_clk), .ext_gate(ext_gate));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op, input logic t, input logic [15:0] d, input logic pe,
                       input logic [2:0] exp_cc);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_timer = t;
        cmd_data = d;
        cmd_parity_err = pe;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_parity_err = 1'b0;
        check("cc_valid", 16'h1, {15'h0, cc_valid});
        check("cc", {13'h0, exp_cc}, {13'h0, cc});
    endtask : cmd
    task automatic read(input logic [7:0] op, input logic t, input logic [15:0] exp);
        cmd(op, t, 16'h0, 1'b0, CC_OK);
        check("rd_data", exp, rd_data);
    endtask : read
    task automatic wait_irq(input int t, input int lim, output int cnt);
        for (cnt = 1; cnt <= lim; cnt++)
        begin
            @(negedge ref_clk);
            if (irq_req[t] === 1'b1)
                return;
        end
        mismatches++;
        $display("[ERR] irq_req expected 1 seen 0");
        summarize();
    endtask : wait_irq
    // acknowledge right at the negedge where the request was seen
    task automatic ack(input int t);
        irq_ack[t] = 1'b1;
        @(negedge ref_clk);
        irq_ack[t] = 1'b0;
    endtask : ack
    task automatic t_reset();
        check("run_state", 16'h0, {14'h0, run_state});
        read(OP_READ_VALUE, 1'b1, CNT_POR_VALUE);
        read(OP_READ_MODE, 1'b0, 16'h0);
    endtask : t_reset
    task automatic t_codes();
        cmd(8'h00, 1'b0, 16'h0, 1'b0, CC_REJECT);
        cmd(8'hFF, 1'b1, 16'h0, 1'b0, CC_REJECT);
        cmd(OP_SET_PERIOD, 1'b0, 16'h2, 1'b1, CC_DATA_CHECK);
        cmd(OP_READ_ID, 1'b0, 16'h0, 1'b1, CC_DATA_CHECK);
        read(OP_READ_VALUE, 1'b0, CNT_POR_VALUE);
        read(OP_READ_ID, 1'b0, DEVICE_ID);
    endtask : t_codes
    task automatic t_period();
        cmd(OP_PREPARE, 1'b0, 16'h1, 1'b0, CC_OK);
        cmd(OP_SET_PERIOD, 1'b0, 16'h2, 1'b0, CC_OK);
        cmd(OP_SET_MODE, 1'b0, 16'hC, 1'b0, CC_OK);
        cmd(OP_PREPARE, 1'b1, 16'h0, 1'b0, CC_OK);
        cmd(OP_SET_MODE, 1'b1, 16'hC, 1'b0, CC_OK);
        cmd(OP_START_PER, 1'b1, 16'h0, 1'b0, CC_OK);
        cmd(OP_START_PER, 1'b0, 16'h0, 1'b0, CC_OK);
        check("run_state", 16'h3, {14'h0, run_state});
        wait_irq(0, 400, n);
        check("first_interval", 16'h1, {15'h0, n inside {[201:300]}});
        check("irq_cc0", {13'h0, ICC_DEVICE_END}, {13'h0, irq_cc0});
        ack(0);
        wait_irq(0, 400, n);
        check("interval", 16'h12C, 16'(n + 1));
        repeat (305) @(negedge ref_clk);
        check("irq_cc0", {13'h0, ICC_EXCEPTION}, {13'h0, irq_cc0});
        cmd(OP_SET_MODE, 1'b0, 16'hC, 1'b0, CC_BUSY);
        cmd(OP_START_PER, 1'b0, 16'h0, 1'b0, CC_BUSY);
        cmd(OP_STOP, 1'b0, 16'h0, 1'b0, CC_BUSY);
        check("irq_req1", 16'h0, {15'h0, irq_req[1]});
        ack(0);
        cmd(OP_STOP, 1'b0, 16'h0, 1'b0, CC_OK);
        check("run_irq0", 16'h0, {14'h0, run_state[0], irq_req[0]});
    endtask : t_period
    task automatic t_ext();
        cmd(OP_DEV_RESET, 1'b1, 16'h0, 1'b0, CC_OK);
        check("run_state", 16'h0, {14'h0, run_state});
        read(OP_READ_MODE, 1'b0, 16'hC);
        cmd(OP_PREPARE, 1'b1, 16'h1, 1'b0, CC_OK);
        cmd(OP_SET_PERIOD, 1'b1, 16'h1, 1'b0, CC_OK);
        cmd(OP_SET_MODE, 1'b1, 16'h2, 1'b0, CC_OK);
        cmd(OP_START_APER, 1'b1, 16'h0, 1'b0, CC_OK);
        pulse_req[1] = 1'b1;
        repeat (6) @(negedge ref_clk);
        read(OP_READ_VALUE, 1'b1, 16'h0);
        cmd(OP_STOP, 1'b1, 16'h0, 1'b0, CC_OK);
        cmd(OP_START_APER, 1'b1, 16'h0, 1'b0, CC_OK);
        read(OP_READ_VALUE, 1'b1, 16'h0);
        pulse_req[1] = 1'b0;
        repeat (6) @(negedge ref_clk);
        pulse_req[1] = 1'b1;
        wait_irq(1, 8, n);
        check("irq_cc1", {13'h0, ICC_DEVICE_END}, {13'h0, irq_cc1});
        ack(1);
        pulse_req[1] = 1'b0;
        read(OP_READ_VALUE, 1'b1, 16'hFFFF);
        cmd(OP_DEV_RESET, 1'b1, 16'h0, 1'b1, CC_OK);
    endtask : t_ext
    task automatic t_gate();
        cmd(OP_SET_PERIOD, 1'b0, 16'h100, 1'b0, CC_OK);
        cmd(OP_SET_MODE, 1'b0, 16'hD, 1'b0, CC_OK);
        cmd(OP_START_PER, 1'b0, 16'h0, 1'b0, CC_OK);
        repeat (300) @(negedge ref_clk);
        read(OP_READ_VALUE, 1'b0, 16'h100);
        gate_req[0] = 1'b1;
        repeat (500) @(negedge ref_clk);
        gate_req[0] = 1'b0;
        wait_irq(0, 8, n);
        check("irq_cc0", {13'h0, ICC_ATTENTION}, {13'h0, irq_cc0});
        check("run_state", 16'h0, {14'h0, run_state});
        cmd(OP_READ_VALUE, 1'b0, 16'h0, 1'b0, CC_OK);
        v = rd_data;
        check("count_drop", 16'h1, {15'h0, (16'h100 - v) inside {[16'h4:16'h6]}});
        repeat (200) @(negedge ref_clk);
        read(OP_READ_VALUE, 1'b0, v);
    endtask : t_gate
    // gated external-clock runs: overrun then gate end, and gate end with device end
    task automatic t_gate_codes();
        cmd(OP_SET_PERIOD, 1'b1, 16'h0, 1'b0, CC_OK);
        cmd(OP_SET_MODE, 1'b1, 16'h3, 1'b0, CC_OK);
        cmd(OP_START_PER, 1'b1, 16'h0, 1'b0, CC_OK);
        gate_req[1] = 1'b1;
        repeat (4) @(negedge ref_clk);
        pulse_req[1] = 1'b1;
        wait_irq(1, 8, n);
        check("irq_cc1", {13'h0, ICC_DEVICE_END}, {13'h0, irq_cc1});
        pulse_req[1] = 1'b0;
        repeat (4) @(negedge ref_clk);
        pulse_req[1] = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("irq_cc1", {13'h0, ICC_EXCEPTION}, {13'h0, irq_cc1});
        gate_req[1] = 1'b0;
        repeat (5) @(negedge ref_clk);
        check("irq_cc1", {13'h0, ICC_ATTN_EXC}, {13'h0, irq_cc1});
        check("run_state", 16'h0, {14'h0, run_state});
        ack(1);
        pulse_req[1] = 1'b0;
        cmd(OP_START_PER, 1'b1, 16'h0, 1'b0, CC_OK);
        gate_req[1] = 1'b1;
        repeat (4) @(negedge ref_clk);
        gate_req[1] = 1'b0;
        @(negedge ref_clk);
        pulse_req[1] = 1'b1;
        wait_irq(1, 8, n);
        check("irq_cc1", {13'h0, ICC_ATTN_DE}, {13'h0, irq_cc1});
        check("run_state", 16'h0, {14'h0, run_state});
        ack(1);
        pulse_req[1] = 1'b0;
    endtask : t_gate_codes
    task automatic t_resets();
        cmd(OP_SET_MODE, 1'b1, 16'h4, 1'b0, CC_OK);
        halt_io = 1'b1;
        @(negedge ref_clk);
        halt_io = 1'b0;
        check("irq_req", 16'h0, {14'h0, irq_req});
        read(OP_READ_MODE, 1'b1, 16'h0);
        read(OP_READ_VALUE, 1'b0, v);
        cmd(OP_SET_PERIOD, 1'b0, 16'h0, 1'b0, CC_OK);
        cmd(OP_SET_MODE, 1'b0, 16'hC, 1'b0, CC_OK);
        sys_reset = 1'b1;
        @(negedge ref_clk);
        sys_reset = 1'b0;
        read(OP_READ_MODE, 1'b0, 16'h0);
        read(OP_READ_VALUE, 1'b0, 16'h0);
        cmd(OP_SET_MODE, 1'b0, 16'hC, 1'b0, CC_OK);
        cmd(OP_START_PER, 1'b0, 16'h0, 1'b0, CC_OK);
        repeat (150) @(negedge ref_clk);
        check("irq_req", 16'h0, {14'h0, irq_req});
    endtask : t_resets
    initial
    begin
        nrst = 1'b0;
        sys_reset = 1'b0;
        halt_io = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_timer = 1'b0;
        cmd_data = 16'h0;
        cmd_parity_err = 1'b0;
        irq_ack = 2'h0;
        pulse_req = 2'h0;
        gate_req = 2'h0;
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_codes();
        t_period();
        t_ext();
        t_gate();
        t_gate_codes();
        t_resets();
        summarize();
    end
endmodule : dual_interval_timer_status_tb_top
`default_nettype wire
